// *** ptc_pkg.sv ***
// Package for the periodic tick counter: register map, fields, reset values
package ptc_pkg;
  // Register offsets (byte addresses)
  localparam logic [3:0] PTC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] PTC_OFS_COUNT  = 4'h4;
  localparam logic [3:0] PTC_OFS_LIMIT  = 4'h8;
  localparam logic [3:0] PTC_OFS_ISTAT  = 4'hc;
  localparam logic [3:0] PTC_OFS_IMASK  = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
  // Control/status field positions
  localparam int PTC_FLAG_BIT = 7;
  localparam int PTC_SRC_HI   = 6;
  localparam int PTC_SRC_LO   = 5;
  localparam int PTC_IE_BIT   = 4;
  localparam int PTC_DIV_HI   = 3;
  // Reset values
  localparam logic [7:0]  PTC_CTRL_RST  = 8'h00;
  localparam logic [7:0]  PTC_LIMIT_RST = 8'h00;
  localparam logic [7:0]  PTC_COUNT_RST = 8'h00;
  localparam logic [17:0] PTC_PRE_RST   = 18'h00000;
  // Source select encodings
  localparam logic [1:0] PTC_SRC_LPO = 2'h0;
  localparam logic [1:0] PTC_SRC_EXT = 2'h1;
  // Power modes
  typedef enum logic [1:0] {PTC_RUN, PTC_WAIT, PTC_LSTOP, PTC_DSTOP} ptc_pmode_e;
endpackage : ptc_pkg

// *** ptc_tick_if.sv ***
// Interface carrying the tick path between the source selector, the prescaler and the top
`timescale 1ns/1ps
interface ptc_tick_if;
  logic        src_edge;
  logic [1:0]  source_select;
  logic [3:0]  divider_select;
  logic        freeze;
  logic        restart;
  logic        tick;
  modport sel (output src_edge, input source_select, output freeze);
  modport pre (input src_edge, input source_select, input divider_select,
               input freeze, input restart, output tick);
  modport top (output source_select, output divider_select, output restart,
               input tick, input src_edge, input freeze);
endinterface : ptc_tick_if

// *** ptc_source_sel.sv ***
// Clock source selection and gating by power mode and debug state
`timescale 1ns/1ps
module ptc_source_sel
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Source clock levels, synchronous to sys_clk
  input  wire logic       low_power_osc_clock,
  input  wire logic       external_ref_clock,
  input  wire logic       internal_ref_clock,
  // Processor state
  input  wire logic [1:0] power_mode,
  input  wire logic       debug_active,
  // Tick path
  ptc_tick_if.sel         tp
);
  logic lvl_ff;
  logic nxt_lvl;
  logic lvl_prev_ff;
  logic nxt_lvl_prev;
  logic gate;

  always_comb begin
    case (tp.source_select)
      PTC_SRC_LPO: nxt_lvl = low_power_osc_clock;
      PTC_SRC_EXT: nxt_lvl = external_ref_clock;
      default:     nxt_lvl = internal_ref_clock;
    endcase
    nxt_lvl_prev = lvl_ff;
    // Only the oscillator source survives deep stop
    gate = !(power_mode == 2'(PTC_DSTOP) && tp.source_select != PTC_SRC_LPO);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lvl_ff      <= 1'b0;
      lvl_prev_ff <= 1'b0;
    end else begin
      lvl_ff      <= nxt_lvl;
      lvl_prev_ff <= nxt_lvl_prev;
    end
  end

  // Wait and light stop keep counting, deep stop only on the oscillator source; debug freezes counting, a restart still clears
  assign tp.src_edge = lvl_ff && !lvl_prev_ff && gate && !debug_active;
  assign tp.freeze   = debug_active;
endmodule : ptc_source_sel

// *** ptc_prescaler.sv ***
// Prescaler with binary and decimal divide values
`timescale 1ns/1ps
module ptc_prescaler
  import ptc_pkg::*;
#(
  parameter int PRE_W = 18
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Tick path
  ptc_tick_if.pre   tp
);
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic             tick_ff;
  logic             nxt_tick;
  logic [PRE_W-1:0] div;

  // Divide table selected by the low source bit
  always_comb begin
    case ({tp.source_select[0], tp.divider_select})
      5'h01: div = PRE_W'(8);      5'h02: div = PRE_W'(32);
      5'h03: div = PRE_W'(64);     5'h04: div = PRE_W'(128);
      5'h05: div = PRE_W'(256);    5'h06: div = PRE_W'(512);
      5'h07: div = PRE_W'(1024);   5'h08: div = PRE_W'(1);
      5'h09: div = PRE_W'(2);      5'h0a: div = PRE_W'(4);
      5'h0b: div = PRE_W'(10);     5'h0c: div = PRE_W'(16);
      5'h0d: div = PRE_W'(100);    5'h0e: div = PRE_W'(500);
      5'h0f: div = PRE_W'(1000);
      5'h11: div = PRE_W'(1024);   5'h12: div = PRE_W'(2048);
      5'h13: div = PRE_W'(4096);   5'h14: div = PRE_W'(8192);
      5'h15: div = PRE_W'(16384);  5'h16: div = PRE_W'(32768);
      5'h17: div = PRE_W'(65536);  5'h18: div = PRE_W'(1000);
      5'h19: div = PRE_W'(2000);   5'h1a: div = PRE_W'(5000);
      5'h1b: div = PRE_W'(10000);  5'h1c: div = PRE_W'(20000);
      5'h1d: div = PRE_W'(50000);  5'h1e: div = PRE_W'(100000);
      5'h1f: div = PRE_W'(200000);
      default: div = '0;
    endcase
  end

  always_comb begin
    nxt_pre  = pre_ff;
    nxt_tick = 1'b0;
    if (tp.restart || div == '0) begin
      nxt_pre = PTC_PRE_RST; // Select 0 stops; a restart clears
    end else if (tp.src_edge && !tp.freeze) begin
      if (pre_ff == div - PRE_W'(1)) begin
        nxt_pre  = PTC_PRE_RST;
        nxt_tick = 1'b1;
      end else begin
        nxt_pre = pre_ff + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pre_ff  <= PTC_PRE_RST;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= nxt_pre;
      tick_ff <= nxt_tick;
    end
  end

  assign tp.tick = tick_ff && !tp.restart;

  pre_range_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    div != '0 |-> pre_ff < div) else $error("prescaler beyond divide");
  pre_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    tp.divider_select == 4'h0 |=> !tick_ff) else $error("tick while off");
endmodule : ptc_prescaler

// *** ptc_top.sv ***
// Periodic tick counter: registers, 8-bit counter, match and interrupt
//
// Functional notes
// - 8-bit counter compared against 8-bit limit
// - Counting continues in wait, irq wakes
// - Counting continues in light stop; in deep stop only on the oscillator source
// - Only oscillator source runs in deep stop
// - Debug freezes counting; config change clears
// - Flag bit 7, write one clears
// - Source select bits 6..5, reset zero
// - Source change clears prescaler and counter
// - Enable bit 4 routes flag to irq; the code also requires mask bit 0 (register at PTC_OFS_ISTAT) clear
// - Divider bits 3..0; change clears counters
// - Divide table by divider and source bit
// - Count up, wrap to zero at limit
// - Flag sets on limit-to-zero step
// - Limit write clears counters; resets zero
// - Count register read only
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ptc_top
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Source clocks and processor state
  input  wire logic       low_power_osc_clock,
  input  wire logic       external_ref_clock,
  input  wire logic       internal_ref_clock,
  input  wire logic [1:0] power_mode,
  input  wire logic       debug_active,
  // Interrupt
  output logic            match_irq
);
  ptc_tick_if tp ();

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] limit_ff, nxt_limit;
  logic [7:0] imask_ff, nxt_imask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       irq_ff, nxt_irq;
  logic       wr_ctrl, wr_limit, wr_mask, cfg_change, match;

  ptc_source_sel u_sel (
    .sys_clk             (sys_clk),
    .resetn              (resetn),
    .low_power_osc_clock (low_power_osc_clock),
    .external_ref_clock  (external_ref_clock),
    .internal_ref_clock  (internal_ref_clock),
    .power_mode          (power_mode),
    .debug_active        (debug_active),
    .tp                  (tp.sel)
  );

  ptc_prescaler #(.PRE_W(18)) u_pre (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tp      (tp.pre)
  );

  assign wr_ctrl  = reg_wr && reg_addr == PTC_OFS_CTRL;
  assign wr_limit = reg_wr && reg_addr == PTC_OFS_LIMIT;
  assign wr_mask  = reg_wr && reg_addr == PTC_OFS_ISTAT;
  // Only a different value counts as a change
  assign cfg_change = wr_ctrl && reg_wdata[PTC_SRC_HI:0] != ctrl_ff[PTC_SRC_HI:0]
                      && (reg_wdata[PTC_SRC_HI:PTC_SRC_LO] != ctrl_ff[PTC_SRC_HI:PTC_SRC_LO]
                      || reg_wdata[PTC_DIV_HI:0] != ctrl_ff[PTC_DIV_HI:0]);
  assign match = tp.tick && count_ff == limit_ff;

  assign tp.source_select  = ctrl_ff[PTC_SRC_HI:PTC_SRC_LO];
  assign tp.divider_select = ctrl_ff[PTC_DIV_HI:0];
  assign tp.restart        = cfg_change || wr_limit;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_limit = limit_ff;
    nxt_imask = imask_ff;
    nxt_count = count_ff;
    if (wr_ctrl) begin
      nxt_ctrl[PTC_SRC_HI:0] = reg_wdata[PTC_SRC_HI:0];
      if (reg_wdata[PTC_FLAG_BIT])
        nxt_ctrl[PTC_FLAG_BIT] = 1'b0; // Writing one clears, zero does nothing
    end
    if (match)
      nxt_ctrl[PTC_FLAG_BIT] = 1'b1; // Set wins over a same-cycle clear
    if (wr_limit)
      nxt_limit = reg_wdata;
    if (wr_mask)
      nxt_imask = reg_wdata;
    // Count register ignores writes
    if (tp.restart)
      nxt_count = PTC_COUNT_RST;
    else if (match)
      nxt_count = PTC_COUNT_RST;
    else if (tp.tick)
      nxt_count = count_ff + 8'h01;
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        PTC_OFS_CTRL:  nxt_rdata = ctrl_ff;
        PTC_OFS_COUNT: nxt_rdata = count_ff;
        PTC_OFS_LIMIT: nxt_rdata = limit_ff;
        PTC_OFS_ISTAT: nxt_rdata = imask_ff;
        default:       nxt_rdata = 8'h00;
      endcase
    end
    // Level request, usable as wake source in wait and stop
    nxt_irq = nxt_ctrl[PTC_FLAG_BIT] && nxt_ctrl[PTC_IE_BIT] && imask_ff[0] == 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_ff  <= PTC_CTRL_RST;
      count_ff <= PTC_COUNT_RST;
      limit_ff <= PTC_LIMIT_RST;
      imask_ff <= 8'h00;
      rdata_ff <= 8'h00;
      irq_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      count_ff <= nxt_count;
      limit_ff <= nxt_limit;
      imask_ff <= nxt_imask;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign match_irq = irq_ff;

  sequence s_match;
    tp.tick && count_ff == limit_ff && !tp.restart;
  endsequence

  wrap_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_match |=> count_ff == 8'h00) else $error("no wrap at limit");
  flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_match |=> ctrl_ff[PTC_FLAG_BIT]) else $error("flag not set");
  step_up_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    tp.tick && !tp.restart && count_ff != limit_ff |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not step");
  hold_debug_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    debug_active && !tp.restart ##1 debug_active && !tp.restart |-> $stable(count_ff))
    else $error("count moved in debug");
  limit_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_limit |=> count_ff == 8'h00) else $error("limit write kept count");
  src_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfg_change |=> count_ff == 8'h00) else $error("config change kept count");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_ctrl && reg_wdata[PTC_FLAG_BIT] && !match |=> !ctrl_ff[PTC_FLAG_BIT])
    else $error("flag not cleared");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_ff[PTC_FLAG_BIT] && ctrl_ff[PTC_IE_BIT] && !imask_ff[0] && !wr_ctrl && !wr_mask
    |=> match_irq) else $error("irq not raised");
  no_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctrl_ff[PTC_IE_BIT] |-> !match_irq)
    else $error("irq while disabled");
  read_late_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == PTC_OFS_COUNT |=> reg_rdata == $past(count_ff))
    else $error("count read wrong");
endmodule : ptc_top

// *** ptc_top_tb.sv ***
// Self-checking testbench for the periodic tick counter
`timescale 1ns/1ps
module ptc_top_tb;
  import ptc_pkg::*;
  logic       sys_clk;
  logic       resetn;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [2:0] src_lvl;
  logic [1:0] power_mode;
  logic       debug_active;
  logic       match_irq;
  int         n_mismatch;
  int         checks_done;

  ptc_top ptc_top_i (
    .sys_clk             (sys_clk),
    .resetn              (resetn),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .low_power_osc_clock (src_lvl[0]),
    .external_ref_clock  (src_lvl[1]),
    .internal_ref_clock  (src_lvl[2]),
    .power_mode          (power_mode),
    .debug_active        (debug_active),
    .match_irq           (match_irq)
  );

  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge sys_clk);
    #1;
    check({7'h00, match_irq}, {7'h00, exp});
  endtask : irq_chk

  // Slow source pulses; the long low phase lets the sync path settle
  task automatic edges(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      src_lvl[which] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      src_lvl[which] <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask : edges

  task automatic t_reset;
    rd_chk(PTC_OFS_CTRL, PTC_CTRL_RST);
    rd_chk(PTC_OFS_LIMIT, PTC_LIMIT_RST);
    wr(PTC_OFS_COUNT, 8'h5a);
    rd_chk(PTC_OFS_COUNT, 8'h00);
    rd_chk(4'h2, 8'h00);
  endtask : t_reset

  task automatic t_wrap_irq;
    wr(PTC_OFS_LIMIT, 8'h03);
    wr(PTC_OFS_CTRL, 8'h08);
    edges(0, 3);
    rd_chk(PTC_OFS_COUNT, 8'h03);
    rd_chk(PTC_OFS_CTRL, 8'h08);
    edges(0, 1);
    rd_chk(PTC_OFS_COUNT, 8'h00);
    rd_chk(PTC_OFS_CTRL, 8'h88);
    irq_chk(1'b0);
    wr(PTC_OFS_CTRL, 8'h18);
    rd_chk(PTC_OFS_CTRL, 8'h98);
    irq_chk(1'b1);
    wr(PTC_OFS_ISTAT, 8'h01);
    irq_chk(1'b0);
    wr(PTC_OFS_ISTAT, 8'h00);
    irq_chk(1'b1);
    wr(PTC_OFS_CTRL, 8'h98);
    rd_chk(PTC_OFS_CTRL, 8'h18);
    irq_chk(1'b0);
    edges(0, 2);
    wr(PTC_OFS_LIMIT, 8'h00);
    rd_chk(PTC_OFS_COUNT, 8'h00);
    edges(0, 1);
    rd_chk(PTC_OFS_CTRL, 8'h98);
    wr(PTC_OFS_CTRL, 8'h88);
    irq_chk(1'b0);
  endtask : t_wrap_irq

  task automatic t_divide;
    wr(PTC_OFS_LIMIT, 8'hff);
    wr(PTC_OFS_CTRL, 8'h09);
    edges(0, 4);
    rd_chk(PTC_OFS_COUNT, 8'h02);
    wr(PTC_OFS_CTRL, 8'h0a);
    rd_chk(PTC_OFS_COUNT, 8'h00);
    edges(0, 8);
    rd_chk(PTC_OFS_COUNT, 8'h02);
    wr(PTC_OFS_CTRL, 8'h2a);
    rd_chk(PTC_OFS_COUNT, 8'h00);
    rd_chk(PTC_OFS_CTRL, 8'h2a);
    wr(PTC_OFS_CTRL, 8'h48);
    edges(2, 2);
    rd_chk(PTC_OFS_COUNT, 8'h02);
    wr(PTC_OFS_CTRL, 8'h40);
    edges(2, 2);
    rd_chk(PTC_OFS_COUNT, 8'h00);
  endtask : t_divide

  task automatic t_debug_power;
    wr(PTC_OFS_CTRL, 8'h48);
    edges(2, 2);
    debug_active <= 1'b1;
    edges(2, 2);
    rd_chk(PTC_OFS_COUNT, 8'h02);
    debug_active <= 1'b0;
    edges(2, 1);
    rd_chk(PTC_OFS_COUNT, 8'h03);
    power_mode <= 2'h3;
    edges(2, 2);
    rd_chk(PTC_OFS_COUNT, 8'h03);
    power_mode <= 2'h2;
    edges(2, 1);
    rd_chk(PTC_OFS_COUNT, 8'h04);
    power_mode <= 2'h1;
    edges(2, 1);
    rd_chk(PTC_OFS_COUNT, 8'h05);
    wr(PTC_OFS_CTRL, 8'h08);
    power_mode <= 2'h3;
    edges(0, 2);
    rd_chk(PTC_OFS_COUNT, 8'h02);
    power_mode <= 2'h0;
  endtask : t_debug_power

  // Internal source on the high table: divide by 1000 needs 1000 source edges
  task automatic t_wide;
    wr(PTC_OFS_LIMIT, 8'hff);
    wr(PTC_OFS_CTRL, 8'h68);
    for (int i = 0; i < 999; i++) begin
      @(posedge sys_clk);
      src_lvl[2] <= 1'b1;
      @(posedge sys_clk);
      src_lvl[2] <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    rd_chk(PTC_OFS_COUNT, 8'h00);
    edges(2, 1);
    rd_chk(PTC_OFS_COUNT, 8'h01);
    rd_chk(PTC_OFS_CTRL, 8'h68);
  endtask : t_wide

  task automatic report_and_stop;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // A full run needs under 3k cycles; the limit leaves ample margin
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    sys_clk      = 1'b0;
    resetn       = 1'b0;
    reg_addr     = 4'h0;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    src_lvl      = 3'h0;
    power_mode   = 2'h0;
    debug_active = 1'b0;
    n_mismatch   = 0;
    checks_done  = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_wrap_irq();
    t_divide();
    t_debug_power();
    t_wide();
    report_and_stop();
  end
endmodule : ptc_top_tb
